// [cmc_pkg.sv]
// package: constants, register map and mode codes of the can mode controller
package cmc_pkg;
  // timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int BIT_TIME_NS = 1000;
  localparam int BIT_CYCLES = (BIT_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int IDLE_BITS = 11;
  localparam int WAKE_FILT_NS = 100;
  localparam int WAKE_FILT_CYCLES = (WAKE_FILT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CFG2 = 8'h04;
  localparam logic [7:0] ADDR_FILT = 8'h08;
  localparam logic [7:0] ADDR_TXCTL = 8'h0C;
  localparam logic [7:0] ADDR_ISTAT = 8'h10;
  localparam logic [7:0] ADDR_IMASK = 8'h14;
  localparam logic [7:0] ADDR_ERRCNT = 8'h18;
  localparam logic [7:0] ADDR_RXBUF = 8'h1C;
  // field positions
  localparam int REQ_LSB = 8;
  localparam int STAT_LSB = 5;
  localparam int WAKE_FILTER_BIT = 14;
  localparam int TX_REQUEST_BIT = 0;
  localparam int TX_ABORTED_BIT = 1;
  localparam int IRQ_WAKE = 0;
  localparam int IRQ_ABORT = 1;
  localparam int IRQ_MODE = 2;
  localparam int IRQ_CAPT = 3;
  localparam int IRQ_W = 4;
  // mode codes, shared by request and status fields
  typedef enum logic [2:0] {
    CMC_NORMAL = 3'b000,
    CMC_DISABLE = 3'b001,
    CMC_LOOPBACK = 3'b010,
    CMC_LISTEN = 3'b011,
    CMC_CONFIG = 3'b100,
    CMC_LISTEN_ALL = 3'b111
  } cmc_mode_e;
  // reset values
  localparam cmc_mode_e MODE_RST = CMC_CONFIG;
  localparam logic [31:0] CFG2_RST = 32'h0000_0000;
  localparam logic [31:0] FILT_RST = 32'h0000_0000;
  localparam logic [IRQ_W-1:0] IMASK_RST = 4'h0;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// [cmc_idle_det.sv]
// bus idle detector: counts consecutive recessive bit samples
`timescale 1ns/1ps
module cmc_idle_det #(
  parameter int IDLE_BITS = cmc_pkg::IDLE_BITS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bit sampling
  input wire logic bit_tick,
  input wire logic clear,
  input wire logic rx_bit,
  // result
  output logic idle
);
  localparam int CW = $clog2(IDLE_BITS + 1);
  localparam logic [CW-1:0] FULL = CW'(IDLE_BITS);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  // a dominant bit or a mode change restarts the count
  assign cnt_d = (clear || (bit_tick && !rx_bit)) ? '0 :
                 (bit_tick && cnt_q != FULL) ? cnt_q + CW'(1) : cnt_q;
  assign idle = (cnt_q == FULL);

  // counter register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// [cmc_wake_filt.sv]
// low-pass filter on the receive line, bypassed when not enabled
`timescale 1ns/1ps
module cmc_wake_filt #(
  parameter int FILT_CYCLES = cmc_pkg::WAKE_FILT_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // line
  input wire logic enable,
  input wire logic rx_raw,
  output logic rx_out
);
  localparam int CW = $clog2(FILT_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(FILT_CYCLES - 1);
  logic [CW-1:0] cnt_q;
  logic filt_q;

  // output follows only a level that stood for the whole filter time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      filt_q <= 1'b1;
    end else if (rx_raw == filt_q) begin
      cnt_q <= '0;
    end else if (cnt_q == LAST) begin
      cnt_q <= '0;
      filt_q <= rx_raw;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  assign rx_out = enable ? filt_q : rx_raw;
endmodule

// [cmc_mode_ctrl.sv]
// can operating-mode controller with axi4-lite register slave
//
// Overview of operation
// - request field 10:8, status field 7:5
// - mode changes out of an active mode only after 11 recessive bits
// - config mode: no traffic, counters cleared
// - protected registers writable only in config
// - config entry waits for transmission end
// - disable: silent, wake flag, counters kept
// - code 001 enters disable after idle
// - disable releases both pins to port
// - wake filter on receive when enabled
// - new transmission waits idle, disable aborts
// - code 000 normal mode owns pins
// - listen-only passive, counters off, tx released
// - code 111 ignores errors, captures assembly buffer
// - loopback ties internal tx to rx
`timescale 1ns/1ps
module cmc_mode_ctrl #(
  parameter int BIT_CYCLES = cmc_pkg::BIT_CYCLES,
  parameter int IDLE_BITS = cmc_pkg::IDLE_BITS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address, data and response
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // can pins and port ownership
  input wire logic bus_receive_pin,
  output logic bus_transmit_pin_out,
  output logic bus_transmit_pin_oe,
  output logic tx_pin_owned,
  output logic rx_pin_owned,
  // protocol engine side
  input wire logic core_tx_bit,
  input wire logic core_tx_active,
  input wire logic core_err,
  input wire logic core_err_tx,
  input wire logic core_err_rx,
  input wire logic core_rx_frame,
  input wire logic [31:0] core_asm_data,
  output logic core_rx_bit,
  output logic core_tx_start,
  output logic core_ack_en,
  // system
  input wire logic sleep_req,
  output logic irq
);
  localparam int DW = $clog2(BIT_CYCLES);
  localparam logic [DW-1:0] DIV_LAST = DW'(BIT_CYCLES - 1);

  cmc_pkg::cmc_mode_e mode_q, mode_d;
  logic [2:0] req_q;
  logic [31:0] cfg2_q, filt_q, rxbuf_q;
  logic [7:0] tec_q, rec_q;
  logic [cmc_pkg::IRQ_W-1:0] ist_q, imask_q, ist_set;
  logic tx_pend_q, tx_abort_q, rxpin_q, txpin_q, rxint_q;
  logic [DW-1:0] div_q;
  logic aw_q, w_q, bvalid_q, rvalid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;

  // mode decode: who may talk, who owns which pin
  logic legal_req, active, tx_cap, own_tx, own_rx, cnt_on, cfg_mode;
  always_comb begin
    legal_req = 1'b1;
    unique case (req_q)
      3'b000, 3'b001, 3'b010, 3'b011, 3'b100, 3'b111: legal_req = 1'b1;
      default: legal_req = 1'b0;
    endcase
    unique case (mode_q)
      cmc_pkg::CMC_NORMAL: {active, tx_cap, own_tx, own_rx, cnt_on} = 5'b11111;
      cmc_pkg::CMC_LISTEN_ALL: {active, tx_cap, own_tx, own_rx, cnt_on} = 5'b10010;
      cmc_pkg::CMC_LISTEN: {active, tx_cap, own_tx, own_rx, cnt_on} = 5'b10010;
      cmc_pkg::CMC_LOOPBACK: {active, tx_cap, own_tx, own_rx, cnt_on} = 5'b11001;
      cmc_pkg::CMC_DISABLE: {active, tx_cap, own_tx, own_rx, cnt_on} = 5'b00000;
      cmc_pkg::CMC_CONFIG: {active, tx_cap, own_tx, own_rx, cnt_on} = 5'b00000;
      default: {active, tx_cap, own_tx, own_rx, cnt_on} = 5'b00000;
    endcase
  end
  assign cfg_mode = (mode_q == cmc_pkg::CMC_CONFIG);

  // bit-rate enable from the clock divider
  wire bit_tick = (div_q == DIV_LAST);

  // receive path: filter only while sleeping, pin sampled into a flop
  wire rx_filt;
  wire bus_idle;
  cmc_wake_filt u_filt (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(cfg2_q[cmc_pkg::WAKE_FILTER_BIT] && sleep_req),
    .rx_raw(bus_receive_pin),
    .rx_out(rx_filt)
  );

  // mode switch: idle bus when active, legal code, never into config mid-frame
  wire mode_chg = legal_req && (req_q != mode_q) && (!active || bus_idle)
                  && !(req_q == cmc_pkg::CMC_CONFIG && core_tx_active);
  assign mode_d = mode_chg ? cmc_pkg::cmc_mode_e'(req_q) : mode_q;

  // restart the idle count on mode entry so a fresh request in an active mode waits 11 bits
  cmc_idle_det #(.IDLE_BITS(IDLE_BITS)) u_idle (
    .aclk(aclk),
    .aresetn(aresetn),
    .bit_tick(bit_tick),
    .clear(mode_chg),
    .rx_bit(rx_filt),
    .idle(bus_idle)
  );

  // transmission start and abort
  wire to_disable = mode_chg && (req_q == cmc_pkg::CMC_DISABLE);
  assign core_tx_start = tx_pend_q && tx_cap && bus_idle && !core_tx_active && !mode_chg;
  wire abort_ev = tx_pend_q && to_disable;
  wire wake_ev = (mode_q == cmc_pkg::CMC_DISABLE) && rxpin_q && !rx_filt;
  wire capt_ev = core_err && (mode_q == cmc_pkg::CMC_LISTEN_ALL);
  assign ist_set = {capt_ev, mode_chg, abort_ev, wake_ev};

  // axi decode; writes land once both address and data are held
  wire wr_go = aw_q && w_q && !bvalid_q;
  wire rd_go = s_axi_arvalid && s_axi_arready;
  wire wr_prot = (awaddr_q == cmc_pkg::ADDR_CFG2) || (awaddr_q == cmc_pkg::ADDR_FILT)
                 || (awaddr_q == cmc_pkg::ADDR_IMASK);
  wire wr_known = wr_prot || (awaddr_q == cmc_pkg::ADDR_CTRL)
                  || (awaddr_q == cmc_pkg::ADDR_TXCTL) || (awaddr_q == cmc_pkg::ADDR_ISTAT);
  wire wr_ok = wr_go && wr_known && (!wr_prot || cfg_mode);
  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [31:0] wbits = wdata_q & wmask;
  wire wr_ctrl = wr_ok && (awaddr_q == cmc_pkg::ADDR_CTRL);
  wire wr_tx = wr_ok && (awaddr_q == cmc_pkg::ADDR_TXCTL) && wbits[cmc_pkg::TX_REQUEST_BIT];
  wire wr_ist = wr_ok && (awaddr_q == cmc_pkg::ADDR_ISTAT);

  // read mux; status field mirrors the accepted mode
  logic [31:0] rd_mux;
  logic rd_known;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_known = 1'b1;
    unique case (s_axi_araddr)
      cmc_pkg::ADDR_CTRL: begin
        rd_mux[cmc_pkg::REQ_LSB +: 3] = req_q;
        rd_mux[cmc_pkg::STAT_LSB +: 3] = mode_q;
      end
      cmc_pkg::ADDR_CFG2: rd_mux = cfg2_q;
      cmc_pkg::ADDR_FILT: rd_mux = filt_q;
      cmc_pkg::ADDR_TXCTL: rd_mux[1:0] = {tx_abort_q, tx_pend_q};
      cmc_pkg::ADDR_ISTAT: rd_mux[cmc_pkg::IRQ_W-1:0] = ist_q;
      cmc_pkg::ADDR_IMASK: rd_mux[cmc_pkg::IRQ_W-1:0] = imask_q;
      cmc_pkg::ADDR_ERRCNT: rd_mux[15:0] = {rec_q, tec_q};
      cmc_pkg::ADDR_RXBUF: rd_mux = rxbuf_q;
      default: rd_known = 1'b0;
    endcase
  end

  // handshakes: one write and one read in flight
  assign s_axi_awready = !aw_q && !bvalid_q;
  assign s_axi_wready = !w_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // axi slave state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {aw_q, w_q, bvalid_q, rvalid_q} <= 4'h0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bresp_q <= cmc_pkg::RESP_OKAY;
      rresp_q <= cmc_pkg::RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        {aw_q, w_q, bvalid_q} <= 3'b001;
        bresp_q <= wr_ok ? cmc_pkg::RESP_OKAY : cmc_pkg::RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (rd_go) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= rd_known ? cmc_pkg::RESP_OKAY : cmc_pkg::RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // mode, configuration and interrupt registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= cmc_pkg::MODE_RST;
      req_q <= cmc_pkg::MODE_RST;
      cfg2_q <= cmc_pkg::CFG2_RST;
      filt_q <= cmc_pkg::FILT_RST;
      imask_q <= cmc_pkg::IMASK_RST;
      ist_q <= '0;
      div_q <= '0;
    end else begin
      mode_q <= mode_d;
      div_q <= bit_tick ? '0 : div_q + DW'(1);
      // request field stays writable so software can leave config mode
      if (wr_ctrl && wstrb_q[1]) req_q <= wdata_q[cmc_pkg::REQ_LSB +: 3];
      if (wr_ok && awaddr_q == cmc_pkg::ADDR_CFG2) cfg2_q <= (cfg2_q & ~wmask) | wbits;
      if (wr_ok && awaddr_q == cmc_pkg::ADDR_FILT) filt_q <= (filt_q & ~wmask) | wbits;
      if (wr_ok && awaddr_q == cmc_pkg::ADDR_IMASK) begin
        imask_q <= wbits[cmc_pkg::IRQ_W-1:0];
      end
      // set wins over write-one-to-clear; config mode leaves flags as they are
      ist_q <= (ist_q & ~(wr_ist ? wbits[cmc_pkg::IRQ_W-1:0] : '0)) | ist_set;
    end
  end
  assign irq = |(ist_q & imask_q);

  // transmit request and abort flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_pend_q <= 1'b0;
      tx_abort_q <= 1'b0;
    end else begin
      if (abort_ev) begin
        tx_pend_q <= 1'b0;
        tx_abort_q <= 1'b1;
      end else if (core_tx_start) begin
        tx_pend_q <= 1'b0;
      end else if (wr_tx) begin
        tx_pend_q <= 1'b1;
        tx_abort_q <= 1'b0;
      end
    end
  end

  // error counters: cleared in config, frozen when disabled or listening
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tec_q <= 8'h00;
      rec_q <= 8'h00;
    end else if (cfg_mode) begin
      tec_q <= 8'h00;
      rec_q <= 8'h00;
    end else if (cnt_on) begin
      if (core_err_tx && tec_q != 8'hFF) tec_q <= tec_q + 8'h01;
      if (core_err_rx && rec_q != 8'hFF) rec_q <= rec_q + 8'h01;
    end
  end

  // receive buffer: good frames, or partial frames on error in listen-all
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxbuf_q <= 32'h0000_0000;
    end else if (capt_ev || (core_rx_frame && active)) begin
      rxbuf_q <= core_asm_data;
    end
  end

  // pin path; both directions register so pins never glitch on mode change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxpin_q <= 1'b1;
      txpin_q <= 1'b1;
      rxint_q <= 1'b1;
    end else begin
      rxpin_q <= rx_filt;
      txpin_q <= own_tx ? core_tx_bit : 1'b1;
      if (mode_q == cmc_pkg::CMC_LOOPBACK) rxint_q <= core_tx_bit;
      else if (own_rx) rxint_q <= rx_filt;
      else rxint_q <= 1'b1;
    end
  end
  assign core_rx_bit = rxint_q;
  assign bus_transmit_pin_out = txpin_q;
  assign bus_transmit_pin_oe = own_tx;
  assign tx_pin_owned = own_tx;
  assign rx_pin_owned = own_rx;
  assign core_ack_en = own_tx;

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_status_mirror: assert property (mode_q != $past(mode_q) |-> mode_q == $past(req_q))
    else $error("mode changed to other than requested code");
  a_mode_idle: assert property (active && !bus_idle |=> $stable(mode_q))
    else $error("active mode changed on a busy bus");
  a_config_silent: assert property (cfg_mode ##1 cfg_mode |-> !bus_transmit_pin_oe
    && core_rx_bit && tec_q == 8'h00 && rec_q == 8'h00)
    else $error("config mode not silent or counters kept");
  a_lock_cfg: assert property (wr_go && !cfg_mode |=> $stable(cfg2_q) && $stable(filt_q))
    else $error("protected register written outside config");
  a_config_defer: assert property (!cfg_mode && core_tx_active |=> !cfg_mode)
    else $error("config entered during a transmission");
  a_disable_keep: assert property ((mode_q == cmc_pkg::CMC_DISABLE) [*2] |-> $stable(tec_q)
    && $stable(rec_q) && !tx_pin_owned && !rx_pin_owned)
    else $error("disable mode changed counters or kept pins");
  a_tx_wait: assert property (core_tx_start |-> bus_idle && tx_cap ##1 !tx_pend_q)
    else $error("transmission started without idle bus");
  a_abort_flag: assert property (abort_ev |=> tx_abort_q && !tx_pend_q
    && mode_q == cmc_pkg::CMC_DISABLE)
    else $error("abort on disable not flagged");
  a_listen_passive: assert property (mode_q == cmc_pkg::CMC_LISTEN |-> !core_ack_en
    && rx_pin_owned && !cnt_on)
    else $error("listen-only mode not passive");
  a_loop_route: assert property ((mode_q == cmc_pkg::CMC_LOOPBACK) [*2] |->
    core_rx_bit == $past(core_tx_bit) && !rx_pin_owned)
    else $error("loopback does not route tx to rx");
  a_capture_buffer: assert property (capt_ev |=> rxbuf_q == $past(core_asm_data) && ist_q[3])
    else $error("listen-all error did not capture buffer");
  c_enter_normal: cover property (mode_chg && req_q == cmc_pkg::CMC_NORMAL);
  c_abort: cover property (abort_ev);
  c_wake: cover property (wake_ev ##1 irq);
  c_loop_tx: cover property (mode_q == cmc_pkg::CMC_LOOPBACK && core_tx_start);
endmodule

// [cmc_bus_node.sv]
// far-side can node model: wired-and bus line with pull-up to recessive
`timescale 1ns/1ps
module cmc_bus_node (
  // clock
  input wire logic aclk,
  // our controller's transmit pin
  input wire logic bus_transmit_pin_out,
  input wire logic bus_transmit_pin_oe,
  // far node stimulus, dominant while high
  input wire logic hold_dominant,
  // resolved line seen at our receive pin
  output logic bus_receive_pin
);
  logic far_dom_q;
  // far node launches its bit on a clock edge, like a real transmitter
  always_ff @(posedge aclk) begin
    far_dom_q <= hold_dominant;
  end
  // an undriven pin falls back to the pull-up, so recessive reads 1
  assign bus_receive_pin = !far_dom_q && (!bus_transmit_pin_oe || bus_transmit_pin_out);
endmodule

// [tb_can_operating_mode_control.sv]
// self-checking bench for the can operating-mode controller
`timescale 1ns/1ps
module tb_can_operating_mode_control;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, core_asm_data = 32'h0, rd;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic bus_receive_pin, bus_transmit_pin_out, bus_transmit_pin_oe, tx_pin_owned, rx_pin_owned;
  logic core_tx_bit = 1'b1, core_tx_active = 1'b0, core_err = 1'b0, core_err_tx = 1'b0;
  logic core_err_rx = 1'b0, core_rx_frame = 1'b0, sleep_req = 1'b0, hold_dominant = 1'b0;
  logic core_rx_bit, core_tx_start, core_ack_en, irq;
  int fail_count = 0;
  int n_checks = 0;

  // 200 mhz clock
  always #2.5 aclk = !aclk;

  // short bit time keeps the 11-bit idle wait at 44 cycles
  cmc_mode_ctrl #(.BIT_CYCLES(4), .IDLE_BITS(11)) cmc_mode_ctrl_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .bus_receive_pin, .bus_transmit_pin_out, .bus_transmit_pin_oe, .tx_pin_owned,
    .rx_pin_owned, .core_tx_bit, .core_tx_active, .core_err, .core_err_tx, .core_err_rx,
    .core_rx_frame, .core_asm_data, .core_rx_bit, .core_tx_start, .core_ack_en,
    .sleep_req, .irq);
  cmc_bus_node cmc_bus_node_inst (.aclk, .bus_transmit_pin_out, .bus_transmit_pin_oe,
    .hold_dominant, .bus_receive_pin);

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // one axi4-lite write; the leading edge keeps valid from being set twice in one step
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 50) check("write handshake", 1'b0, 1'b1);
  endtask

  task automatic axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 50) check("read handshake", 1'b0, 1'b1);
  endtask

  task automatic set_mode(input cmc_pkg::cmc_mode_e m);
    axi_wr(cmc_pkg::ADDR_CTRL, {21'h0, m, 8'h00});
  endtask

  // polls the status field; the bound covers the idle wait several times over
  task automatic wait_mode(input cmc_pkg::cmc_mode_e m);
    int n;
    n = 0;
    do begin
      axi_rd(cmc_pkg::ADDR_CTRL);
      n++;
    end while (rd[cmc_pkg::STAT_LSB +: 3] !== m && n < 100);
    check("mode status", rd[cmc_pkg::STAT_LSB +: 3], m);
  endtask

  task automatic err_pulse(input logic rx_too);
    core_err_tx <= 1'b1;
    core_err_rx <= rx_too;
    @(posedge aclk);
    core_err_tx <= 1'b0;
    core_err_rx <= 1'b0;
  endtask

  task automatic dom_pulse(input int k);
    hold_dominant <= 1'b1;
    repeat (k) @(posedge aclk);
    hold_dominant <= 1'b0;
    repeat (30) @(posedge aclk);
    axi_rd(cmc_pkg::ADDR_ISTAT);
  endtask

  task automatic s_reset;
    axi_rd(cmc_pkg::ADDR_CTRL);
    check("reset status", rd[cmc_pkg::STAT_LSB +: 3], cmc_pkg::CMC_CONFIG);
    check("reset request", rd[cmc_pkg::REQ_LSB +: 3], cmc_pkg::CMC_CONFIG);
    check("reset tx oe", bus_transmit_pin_oe, 1'b0);
    axi_rd(8'hFC);
    check("unmapped resp", rsp, cmc_pkg::RESP_SLVERR);
  endtask

  task automatic s_normal;
    axi_wr(cmc_pkg::ADDR_CFG2, 32'h0000_4000);
    check("cfg2 open in config", rsp, cmc_pkg::RESP_OKAY);
    axi_wr(cmc_pkg::ADDR_IMASK, 32'h0000_000F);
    set_mode(cmc_pkg::CMC_NORMAL);
    wait_mode(cmc_pkg::CMC_NORMAL);
    check("normal tx oe", bus_transmit_pin_oe, 1'b1);
    check("normal rx owned", rx_pin_owned, 1'b1);
    check("normal ack", core_ack_en, 1'b1);
    // pin out registers once, receive path registers the resolved line once more
    core_tx_bit <= 1'b0;
    repeat (3) @(posedge aclk);
    check("normal tx pin", bus_transmit_pin_out, 1'b0);
    check("normal rx path", core_rx_bit, 1'b0);
    core_tx_bit <= 1'b1;
    err_pulse(1'b1);
    axi_rd(cmc_pkg::ADDR_ERRCNT);
    check("error counts", rd, 32'h0000_0101);
    axi_wr(cmc_pkg::ADDR_CFG2, 32'h0000_0000);
    check("cfg2 locked resp", rsp, cmc_pkg::RESP_SLVERR);
    axi_rd(cmc_pkg::ADDR_CFG2);
    check("cfg2 kept", rd, 32'h0000_4000);
  endtask

  task automatic s_defer;
    core_tx_active <= 1'b1;
    set_mode(cmc_pkg::CMC_CONFIG);
    repeat (150) @(posedge aclk);
    axi_rd(cmc_pkg::ADDR_CTRL);
    check("config deferred", rd[cmc_pkg::STAT_LSB +: 3], cmc_pkg::CMC_NORMAL);
    core_tx_active <= 1'b0;
    wait_mode(cmc_pkg::CMC_CONFIG);
    axi_rd(cmc_pkg::ADDR_ERRCNT);
    check("counters cleared", rd, 32'h0);
  endtask

  // dominant bus holds off the disable switch, so the pending request is aborted
  task automatic s_abort;
    set_mode(cmc_pkg::CMC_NORMAL);
    wait_mode(cmc_pkg::CMC_NORMAL);
    hold_dominant <= 1'b1;
    axi_wr(cmc_pkg::ADDR_TXCTL, 32'h0000_0001);
    err_pulse(1'b0);
    set_mode(cmc_pkg::CMC_DISABLE);
    repeat (150) @(posedge aclk);
    axi_rd(cmc_pkg::ADDR_CTRL);
    check("held while busy", rd[cmc_pkg::STAT_LSB +: 3], cmc_pkg::CMC_NORMAL);
    hold_dominant <= 1'b0;
    wait_mode(cmc_pkg::CMC_DISABLE);
    check("disable tx oe", bus_transmit_pin_oe, 1'b0);
    check("disable tx owned", tx_pin_owned, 1'b0);
    check("disable rx owned", rx_pin_owned, 1'b0);
    axi_rd(cmc_pkg::ADDR_TXCTL);
    check("abort flags", rd[1:0], 2'b10);
    axi_rd(cmc_pkg::ADDR_ISTAT);
    check("abort status", rd[cmc_pkg::IRQ_ABORT], 1'b1);
    err_pulse(1'b0);
    axi_rd(cmc_pkg::ADDR_ERRCNT);
    check("counters kept", rd, 32'h0000_0001);
  endtask

  task automatic s_wake;
    sleep_req <= 1'b1;
    axi_wr(cmc_pkg::ADDR_ISTAT, 32'h0000_000F);
    check("irq after clear", irq, 1'b0);
    dom_pulse(10);
    check("glitch filtered", rd[cmc_pkg::IRQ_WAKE], 1'b0);
    dom_pulse(40);
    check("wake flag", rd[cmc_pkg::IRQ_WAKE], 1'b1);
    check("wake irq", irq, 1'b1);
    axi_wr(cmc_pkg::ADDR_ISTAT, 32'h0000_0001);
    check("wake cleared irq", irq, 1'b0);
    sleep_req <= 1'b0;
    dom_pulse(10);
    check("filter bypassed", rd[cmc_pkg::IRQ_WAKE], 1'b1);
  endtask

  // mask and clear, done in config because the mask is locked elsewhere
  task automatic s_irq;
    set_mode(cmc_pkg::CMC_CONFIG);
    wait_mode(cmc_pkg::CMC_CONFIG);
    axi_rd(cmc_pkg::ADDR_ISTAT);
    check("flags kept in config", rd[cmc_pkg::IRQ_WAKE], 1'b1);
    axi_wr(cmc_pkg::ADDR_IMASK, 32'h0);
    check("masked irq", irq, 1'b0);
    axi_wr(cmc_pkg::ADDR_IMASK, 32'h0000_0001);
    check("unmasked irq", irq, 1'b1);
    axi_wr(cmc_pkg::ADDR_ISTAT, 32'h0000_000F);
    check("cleared irq", irq, 1'b0);
  endtask

  task automatic s_modes;
    int n;
    axi_wr(cmc_pkg::ADDR_CTRL, 32'h0000_0500);
    repeat (10) @(posedge aclk);
    wait_mode(cmc_pkg::CMC_CONFIG);
    set_mode(cmc_pkg::CMC_LISTEN);
    wait_mode(cmc_pkg::CMC_LISTEN);
    check("listen tx oe", bus_transmit_pin_oe, 1'b0);
    check("listen rx owned", rx_pin_owned, 1'b1);
    check("listen ack", core_ack_en, 1'b0);
    err_pulse(1'b1);
    axi_rd(cmc_pkg::ADDR_ERRCNT);
    check("listen counters", rd, 32'h0);
    set_mode(cmc_pkg::CMC_CONFIG);
    wait_mode(cmc_pkg::CMC_CONFIG);
    set_mode(cmc_pkg::CMC_LOOPBACK);
    wait_mode(cmc_pkg::CMC_LOOPBACK);
    check("loop rx owned", rx_pin_owned, 1'b0);
    core_tx_bit <= 1'b0;
    repeat (3) @(posedge aclk);
    check("loop rx bit", core_rx_bit, 1'b0);
    core_tx_bit <= 1'b1;
    // request made soon after entry must sit until 11 recessive bits pass
    axi_wr(cmc_pkg::ADDR_TXCTL, 32'h0000_0001);
    axi_rd(cmc_pkg::ADDR_TXCTL);
    check("tx held for idle", rd[1:0], 2'b01);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (core_tx_start !== 1'b1 && n < 100);
    check("tx start", core_tx_start, 1'b1);
    axi_rd(cmc_pkg::ADDR_TXCTL);
    check("tx request taken", rd[1:0], 2'b00);
    set_mode(cmc_pkg::CMC_CONFIG);
    wait_mode(cmc_pkg::CMC_CONFIG);
    set_mode(cmc_pkg::CMC_LISTEN_ALL);
    wait_mode(cmc_pkg::CMC_LISTEN_ALL);
    core_asm_data <= 32'hC0DE_1234;
    core_err <= 1'b1;
    @(posedge aclk);
    core_err <= 1'b0;
    axi_rd(cmc_pkg::ADDR_RXBUF);
    check("captured buffer", rd, 32'hC0DE_1234);
    axi_rd(cmc_pkg::ADDR_ISTAT);
    check("capture status", rd[cmc_pkg::IRQ_CAPT], 1'b1);
    core_asm_data <= 32'h0000_5A5A;
    core_rx_frame <= 1'b1;
    @(posedge aclk);
    core_rx_frame <= 1'b0;
    axi_rd(cmc_pkg::ADDR_RXBUF);
    check("frame stored", rd, 32'h0000_5A5A);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    s_reset();
    s_normal();
    s_defer();
    s_abort();
    s_wake();
    s_irq();
    s_modes();
    tally_and_finish();
  end

  // whole run needs well under a thousand cycles; this is forty times that
  initial begin
    repeat (40000) @(posedge aclk);
    fail_count++;
    tally_and_finish();
  end
endmodule
